//--- verilog/mic_cfg.svh
/*
 Register offsets, field positions, reset values, edge codes and vector
 addresses of the interrupt controller.
 Assumes it is included by bare name; definitions only.
*/
`ifndef MIC_CFG_SVH
`define MIC_CFG_SVH
// Register map on the plain register port
`define MIC_ADDR_W 4
`define MIC_OFF_EDGE 4'h0
`define MIC_OFF_CTRL0 4'h1
`define MIC_OFF_CTRL1 4'h2
`define MIC_OFF_CTRL2 4'h3
`define MIC_OFF_TIMER0_MATCH_IRQ_CTRL 4'h4
`define MIC_OFF_TIMER12_MATCH_IRQ_CTRL_LARGE 4'h5
`define MIC_OFF_EEPROM_LOWVOLT_IRQ_CTRL 4'h6
`define MIC_OFF_CMPC 4'h7
`define MIC_RST_BYTE 8'h00
// Sub-register fields: high flag, low flag, high enable, low enable
`define MIC_B_FHI 5
`define MIC_B_FLO 4
`define MIC_B_EHI 1
`define MIC_B_ELO 0
`define MIC_B_T2_FA 7
`define MIC_B_T2_FP 6
`define MIC_B_T2_EA 3
`define MIC_B_T2_EP 2
`define MIC_TIMER0_MATCH_IRQ_CTRL_RSVD 8'hCC
// Control register 0 fields
`define MIC_B_MF0F 6
`define MIC_B_CPF 5
`define MIC_B_INT0F 4
`define MIC_B_MF0E 3
`define MIC_B_CPE 2
`define MIC_B_INT0E 1
`define MIC_B_EMI 0
// Edge select codes and field positions
`define MIC_EDGE_OFF 2'b00
`define MIC_EDGE_RISE 2'b01
`define MIC_EDGE_FALL 2'b10
`define MIC_EDGE_BOTH 2'b11
`define MIC_EDGE_W 2
`define MIC_B_EDGE1 2
`define MIC_B_EDGE0 0
// Sources in priority order, index 0 highest
`define MIC_NSRC 6
`define MIC_SRC_W 3
`define MIC_SRC_INT0 3'd0
`define MIC_SRC_CP 3'd1
`define MIC_SRC_MF0 3'd2
`define MIC_SRC_MF1 3'd3
`define MIC_SRC_MF2 3'd4
`define MIC_SRC_INT1 3'd5
`define MIC_SRC_MASK_SMALL 6'h3D
`define MIC_SRC_MASK_LARGE 6'h3F
// Member flags: T0P,T0A,T1P,T1A,T2P,T2A,LV,EE
`define MIC_NSUB 8
`define MIC_SUB_MASK_SMALL 8'hCF
`define MIC_SUB_MASK_LARGE 8'hFF
// Vector addresses
`define MIC_PC_W 13
`define MIC_VEC_INT0 13'h0004
`define MIC_VEC_CP 13'h0008
`define MIC_VEC_MF0 13'h000C
`define MIC_VEC_MF1 13'h0010
`define MIC_VEC_MF2 13'h0014
`define MIC_VEC_INT1 13'h0018
`endif

//--- verilog/mic_pkg.sv
/*
 Types shared by the interrupt controller files.
 Assumes mic_cfg.svh is on the include path.
*/
`include "mic_cfg.svh"
package mic_pkg;
    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        MIC_ST_IDLE = 3'b001,
        MIC_ST_TAKE = 3'b010,
        MIC_ST_RET = 3'b100
    } mic_state_t;
    // Timer compare events, one bit per timer
    typedef struct packed {
        logic [2:0] cmpa;
        logic [2:0] cmpp;
    } mic_tm_evt_t;
    // Commands to the core program counter and stack
    typedef struct packed {
        logic ack;
        logic push;
        logic pop;
        logic pc_load;
        logic [`MIC_SRC_W-1:0] src;
        logic [`MIC_PC_W-1:0] pc_value;
        logic [`MIC_PC_W-1:0] push_value;
    } mic_core_out_t;
endpackage

//--- verilog/mic_edge_det.sv
/*
 Synchronises one asynchronous level and reports a selected edge as a
 one-cycle pulse. Assumes ref_clk and a synchronous active-low reset.
*/
`timescale 1ns/100ps
`include "mic_cfg.svh"
module mic_edge_det
    import mic_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Level and selection
    input wire logic async_in,
    input wire logic [`MIC_EDGE_W-1:0] edge_sel,
    input wire logic arm,
    // Edge pulse
    output logic evt
);
    logic meta_r, sync_r, prev_r;
    logic meta_nxt, sync_nxt, prev_nxt;
    logic rise, fall;

    // Two flops before any logic looks at the level
    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
        prev_nxt = sync_r;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            prev_r <= prev_nxt;
        end
    end

    // Edge match against the selected type; code 00 disables
    always_comb begin
        rise = sync_r & ~prev_r;
        fall = ~sync_r & prev_r;
        evt = 1'b0;
        case (edge_sel)
            `MIC_EDGE_RISE: evt = arm & rise;
            `MIC_EDGE_FALL: evt = arm & fall;
            `MIC_EDGE_BOTH: evt = arm & (rise | fall);
            default: evt = 1'b0;
        endcase
    end
endmodule

//--- verilog/mic_prio.sv
/*
 Fixed-priority picker: lowest index wins.
 Assumes a request vector from logic on the same clock.
*/
`timescale 1ns/100ps
`include "mic_cfg.svh"
module mic_prio #(
    parameter int N = `MIC_NSRC,
    parameter int W = `MIC_SRC_W
) (
    // Requests
    input wire logic [N-1:0] req,
    // Winner
    output logic any,
    output logic [W-1:0] idx
);
    // Walk down so that the lowest set index is the last to write
    always_comb begin
        any = |req;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = W'(i);
            end
        end
    end
endmodule

//--- verilog/mic_top.sv
/*
 Interrupt controller: request flags and enables, multi-function grouping,
 external pin and comparator edge sources, vectoring to the core.
 Assumes peripheral events are one-cycle pulses on ref_clk, pins and the
 comparator output are asynchronous, and the core acts on the command
 struct in the cycle it is shown.
*/
// Summary of operation
// - First sub-register: timer 0 A/P flags bits 5/4, enables 1/0.
// - Second sub-register: timer 1 A/P flags bits 5/4, enables 1/0.
// - Larger variant adds timer 2 flags bits 7/6, enables 3/2.
// - Third sub-register: EEPROM/low-voltage flags bits 5/4, enables 1/0.
// - Source events set their flag regardless of the enable bit, except pin edges, which are armed only when enabled.
// - Vectoring happens only when the source enable is high.
// - Global enable low suppresses every interrupt.
// - On take, push next address and load the vector.
// - Return-from-interrupt pops the saved address into the counter.
// - Timer, EEPROM, low-voltage sources share grouped vectors.
// - Servicing clears the global enable, so no nesting.
// - Requests during service still set and keep their flags.
// - No acknowledge while the stack is full.
// - Any set request flag wakes the device.
// - Pin flag sets on a transition of the selected edge type.
// - Pin acts as interrupt only when enabled and configured input.
// - Servicing a pin interrupt clears its flag and global enable.
// - Edge control selects rising, falling, both, or disabled per pin.
// - Larger variant: comparator flag on output change, cleared on service.
// - Two-bit comparator edge field selects the triggering transitions.
// - Edge codes: 00 off, 01 rising, 10 falling, 11 both.
// - Group flag sets on a newly set member flag whose enable is high; service clears group only.
`timescale 1ns/100ps
`include "mic_cfg.svh"
module mic_top
    import mic_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [`MIC_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata_r,
    // Peripheral events, one-cycle pulses
    input wire mic_tm_evt_t tm_evt,
    input wire logic eeprom_done_evt,
    input wire logic low_voltage_evt,
    // Asynchronous levels
    input wire logic [1:0] ext_pin_in,
    input wire logic [1:0] ext_pin_dir_in,
    input wire logic comparator_out,
    // Core side
    input wire logic [`MIC_PC_W-1:0] next_pc,
    input wire logic [`MIC_PC_W-1:0] stack_top,
    input wire logic stack_full,
    input wire logic return_from_interrupt,
    output mic_core_out_t core_r,
    output logic wake_r
);
    localparam logic [`MIC_NSRC-1:0] SRC_MASK = LARGE_VARIANT ? `MIC_SRC_MASK_LARGE : `MIC_SRC_MASK_SMALL;
    localparam logic [`MIC_NSUB-1:0] SUB_MASK = LARGE_VARIANT ? `MIC_SUB_MASK_LARGE : `MIC_SUB_MASK_SMALL;

    mic_state_t state_r, state_nxt;
    mic_core_out_t core_nxt;
    logic [`MIC_NSRC-1:0] src_flag_r, src_flag_nxt, src_en_r, src_en_nxt, src_evt, pend;
    logic [`MIC_NSUB-1:0] sub_flag_r, sub_flag_nxt, sub_en_r, sub_en_nxt, sub_evt, sub_rise;
    logic emi_r, emi_nxt, wake_nxt;
    logic [3:0] edge_r, edge_nxt;
    logic [`MIC_EDGE_W-1:0] cmp_edge_r, cmp_edge_nxt;
    logic [7:0] rdata_nxt;
    logic [1:0] ext_evt;
    logic cmp_evt, pick_any, take_now;
    logic [`MIC_SRC_W-1:0] pick_idx;
    logic [`MIC_PC_W-1:0] vec;

    // Pin sources armed only when enabled and configured as input
    mic_edge_det u_ext0 (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in(ext_pin_in[0]),
        .edge_sel(edge_r[`MIC_B_EDGE0 +: `MIC_EDGE_W]),
        .arm(src_en_r[`MIC_SRC_INT0] & ext_pin_dir_in[0]),
        .evt(ext_evt[0])
    );
    mic_edge_det u_ext1 (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in(ext_pin_in[1]),
        .edge_sel(edge_r[`MIC_B_EDGE1 +: `MIC_EDGE_W]),
        .arm(src_en_r[`MIC_SRC_INT1] & ext_pin_dir_in[1]),
        .evt(ext_evt[1])
    );
    // Comparator source exists only on the larger variant
    mic_edge_det u_cmp (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in(comparator_out),
        .edge_sel(cmp_edge_r),
        .arm(LARGE_VARIANT),
        .evt(cmp_evt)
    );

    // Pending requests, gated by each enable, picked by priority
    assign pend = src_flag_r & src_en_r & SRC_MASK;
    mic_prio u_prio (
        .req(pend),
        .any(pick_any),
        .idx(pick_idx)
    );
    // Stack full or a return in progress holds the acknowledge off
    assign take_now = (state_r == MIC_ST_IDLE) & emi_r & pick_any & ~stack_full & ~return_from_interrupt;

    // Each source has its own vector; grouped sources share one
    always_comb begin
        case (pick_idx)
            `MIC_SRC_INT0: vec = `MIC_VEC_INT0;
            `MIC_SRC_CP: vec = `MIC_VEC_CP;
            `MIC_SRC_MF0: vec = `MIC_VEC_MF0;
            `MIC_SRC_MF1: vec = `MIC_VEC_MF1;
            `MIC_SRC_MF2: vec = `MIC_VEC_MF2;
            `MIC_SRC_INT1: vec = `MIC_VEC_INT1;
            default: vec = `MIC_VEC_INT0;
        endcase
    end

    // Member events: T0P,T0A,T1P,T1A,T2P,T2A,LV,EE
    assign sub_evt = {eeprom_done_evt, low_voltage_evt, tm_evt.cmpa[2], tm_evt.cmpp[2],
                      tm_evt.cmpa[1], tm_evt.cmpp[1], tm_evt.cmpa[0], tm_evt.cmpp[0]} & SUB_MASK;

    // Register writes, service clears, then hardware sets win
    always_comb begin
        sub_flag_nxt = sub_flag_r;
        sub_en_nxt = sub_en_r;
        src_flag_nxt = src_flag_r;
        src_en_nxt = src_en_r;
        emi_nxt = emi_r;
        edge_nxt = edge_r;
        cmp_edge_nxt = cmp_edge_r;
        if (reg_wr) begin
            case (reg_addr)
                `MIC_OFF_EDGE: edge_nxt = reg_wdata[`MIC_B_EDGE1+`MIC_EDGE_W-1:`MIC_B_EDGE0];
                `MIC_OFF_CTRL0: begin
                    src_flag_nxt[`MIC_SRC_MF0] = reg_wdata[`MIC_B_MF0F];
                    src_flag_nxt[`MIC_SRC_CP] = reg_wdata[`MIC_B_CPF];
                    src_flag_nxt[`MIC_SRC_INT0] = reg_wdata[`MIC_B_INT0F];
                    src_en_nxt[`MIC_SRC_MF0] = reg_wdata[`MIC_B_MF0E];
                    src_en_nxt[`MIC_SRC_CP] = reg_wdata[`MIC_B_CPE];
                    src_en_nxt[`MIC_SRC_INT0] = reg_wdata[`MIC_B_INT0E];
                    emi_nxt = reg_wdata[`MIC_B_EMI];
                end
                `MIC_OFF_CTRL1: begin
                    src_flag_nxt[`MIC_SRC_MF2] = reg_wdata[`MIC_B_FHI];
                    src_flag_nxt[`MIC_SRC_MF1] = reg_wdata[`MIC_B_FLO];
                    src_en_nxt[`MIC_SRC_MF2] = reg_wdata[`MIC_B_EHI];
                    src_en_nxt[`MIC_SRC_MF1] = reg_wdata[`MIC_B_ELO];
                end
                `MIC_OFF_CTRL2: begin
                    src_flag_nxt[`MIC_SRC_INT1] = reg_wdata[`MIC_B_FHI];
                    src_en_nxt[`MIC_SRC_INT1] = reg_wdata[`MIC_B_EHI];
                end
                `MIC_OFF_TIMER0_MATCH_IRQ_CTRL: begin
                    sub_flag_nxt[1] = reg_wdata[`MIC_B_FHI];
                    sub_flag_nxt[0] = reg_wdata[`MIC_B_FLO];
                    sub_en_nxt[1] = reg_wdata[`MIC_B_EHI];
                    sub_en_nxt[0] = reg_wdata[`MIC_B_ELO];
                end
                `MIC_OFF_TIMER12_MATCH_IRQ_CTRL_LARGE: begin
                    sub_flag_nxt[3] = reg_wdata[`MIC_B_FHI];
                    sub_flag_nxt[2] = reg_wdata[`MIC_B_FLO];
                    sub_en_nxt[3] = reg_wdata[`MIC_B_EHI];
                    sub_en_nxt[2] = reg_wdata[`MIC_B_ELO];
                    sub_flag_nxt[5] = reg_wdata[`MIC_B_T2_FA];
                    sub_flag_nxt[4] = reg_wdata[`MIC_B_T2_FP];
                    sub_en_nxt[5] = reg_wdata[`MIC_B_T2_EA];
                    sub_en_nxt[4] = reg_wdata[`MIC_B_T2_EP];
                end
                `MIC_OFF_EEPROM_LOWVOLT_IRQ_CTRL: begin
                    sub_flag_nxt[7] = reg_wdata[`MIC_B_FHI];
                    sub_flag_nxt[6] = reg_wdata[`MIC_B_FLO];
                    sub_en_nxt[7] = reg_wdata[`MIC_B_EHI];
                    sub_en_nxt[6] = reg_wdata[`MIC_B_ELO];
                end
                `MIC_OFF_CMPC: cmp_edge_nxt = reg_wdata[`MIC_EDGE_W-1:0];
                default: ;
            endcase
        end
        // Service: clear the taken flag and the global enable
        if (take_now) begin
            src_flag_nxt[pick_idx] = 1'b0;
            emi_nxt = 1'b0;
        end
        // Member flags set regardless of enables; set beats a clear
        sub_flag_nxt = (sub_flag_nxt | sub_evt) & SUB_MASK;
        sub_en_nxt = sub_en_nxt & SUB_MASK;
        // A member flag newly set with its enable marks its group
        sub_rise = sub_flag_nxt & ~sub_flag_r & sub_en_nxt;
        src_evt = '0;
        src_evt[`MIC_SRC_INT0] = ext_evt[0];
        src_evt[`MIC_SRC_INT1] = ext_evt[1];
        src_evt[`MIC_SRC_CP] = cmp_evt;
        src_evt[`MIC_SRC_MF0] = |sub_rise[1:0];
        src_evt[`MIC_SRC_MF1] = |sub_rise[5:2];
        src_evt[`MIC_SRC_MF2] = |sub_rise[7:6];
        src_flag_nxt = (src_flag_nxt | src_evt) & SRC_MASK;
        src_en_nxt = src_en_nxt & SRC_MASK;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sub_flag_r <= '0;
            sub_en_r <= '0;
            src_flag_r <= '0;
            src_en_r <= '0;
            emi_r <= 1'b0;
            edge_r <= '0;
            cmp_edge_r <= '0;
        end else begin
            sub_flag_r <= sub_flag_nxt;
            sub_en_r <= sub_en_nxt;
            src_flag_r <= src_flag_nxt;
            src_en_r <= src_en_nxt;
            emi_r <= emi_nxt;
            edge_r <= edge_nxt;
            cmp_edge_r <= cmp_edge_nxt;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_comb begin
        rdata_nxt = `MIC_RST_BYTE;
        if (reg_rd) begin
            case (reg_addr)
                `MIC_OFF_EDGE: rdata_nxt[`MIC_B_EDGE1+`MIC_EDGE_W-1:`MIC_B_EDGE0] = edge_r;
                `MIC_OFF_CTRL0: begin
                    rdata_nxt[`MIC_B_MF0F] = src_flag_r[`MIC_SRC_MF0];
                    rdata_nxt[`MIC_B_CPF] = src_flag_r[`MIC_SRC_CP];
                    rdata_nxt[`MIC_B_INT0F] = src_flag_r[`MIC_SRC_INT0];
                    rdata_nxt[`MIC_B_MF0E] = src_en_r[`MIC_SRC_MF0];
                    rdata_nxt[`MIC_B_CPE] = src_en_r[`MIC_SRC_CP];
                    rdata_nxt[`MIC_B_INT0E] = src_en_r[`MIC_SRC_INT0];
                    rdata_nxt[`MIC_B_EMI] = emi_r;
                end
                `MIC_OFF_CTRL1: begin
                    rdata_nxt[`MIC_B_FHI] = src_flag_r[`MIC_SRC_MF2];
                    rdata_nxt[`MIC_B_FLO] = src_flag_r[`MIC_SRC_MF1];
                    rdata_nxt[`MIC_B_EHI] = src_en_r[`MIC_SRC_MF2];
                    rdata_nxt[`MIC_B_ELO] = src_en_r[`MIC_SRC_MF1];
                end
                `MIC_OFF_CTRL2: begin
                    rdata_nxt[`MIC_B_FHI] = src_flag_r[`MIC_SRC_INT1];
                    rdata_nxt[`MIC_B_EHI] = src_en_r[`MIC_SRC_INT1];
                end
                `MIC_OFF_TIMER0_MATCH_IRQ_CTRL: begin
                    rdata_nxt[`MIC_B_FHI] = sub_flag_r[1];
                    rdata_nxt[`MIC_B_FLO] = sub_flag_r[0];
                    rdata_nxt[`MIC_B_EHI] = sub_en_r[1];
                    rdata_nxt[`MIC_B_ELO] = sub_en_r[0];
                end
                `MIC_OFF_TIMER12_MATCH_IRQ_CTRL_LARGE: begin
                    rdata_nxt[`MIC_B_FHI] = sub_flag_r[3];
                    rdata_nxt[`MIC_B_FLO] = sub_flag_r[2];
                    rdata_nxt[`MIC_B_EHI] = sub_en_r[3];
                    rdata_nxt[`MIC_B_ELO] = sub_en_r[2];
                    rdata_nxt[`MIC_B_T2_FA] = sub_flag_r[5];
                    rdata_nxt[`MIC_B_T2_FP] = sub_flag_r[4];
                    rdata_nxt[`MIC_B_T2_EA] = sub_en_r[5];
                    rdata_nxt[`MIC_B_T2_EP] = sub_en_r[4];
                end
                `MIC_OFF_EEPROM_LOWVOLT_IRQ_CTRL: begin
                    rdata_nxt[`MIC_B_FHI] = sub_flag_r[7];
                    rdata_nxt[`MIC_B_FLO] = sub_flag_r[6];
                    rdata_nxt[`MIC_B_EHI] = sub_en_r[7];
                    rdata_nxt[`MIC_B_ELO] = sub_en_r[6];
                end
                `MIC_OFF_CMPC: rdata_nxt[`MIC_EDGE_W-1:0] = cmp_edge_r;
                default: rdata_nxt = `MIC_RST_BYTE;
            endcase
        end
    end

    // Sequencer: a return always wins over a new take in the same cycle
    always_comb begin
        state_nxt = MIC_ST_IDLE;
        core_nxt = '0;
        wake_nxt = (|src_flag_r) | (|sub_flag_r);
        case (state_r)
            MIC_ST_IDLE, MIC_ST_TAKE, MIC_ST_RET: begin
                if (return_from_interrupt) begin
                    state_nxt = MIC_ST_RET;
                    core_nxt.pop = 1'b1;
                    core_nxt.pc_load = 1'b1;
                    core_nxt.pc_value = stack_top;
                end else if (take_now) begin
                    state_nxt = MIC_ST_TAKE;
                    core_nxt.ack = 1'b1;
                    core_nxt.push = 1'b1;
                    core_nxt.push_value = next_pc;
                    core_nxt.pc_load = 1'b1;
                    core_nxt.pc_value = vec;
                    core_nxt.src = pick_idx;
                end
            end
            default: state_nxt = MIC_ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r <= MIC_ST_IDLE;
            core_r <= '0;
            wake_r <= 1'b0;
            reg_rdata_r <= `MIC_RST_BYTE;
        end else begin
            state_r <= state_nxt;
            core_r <= core_nxt;
            wake_r <= wake_nxt;
            reg_rdata_r <= rdata_nxt;
        end
    end

    // Checks on the vectoring and flag behaviour
    property p_take_needs_emi;
        @(posedge ref_clk) disable iff (!rst_n) core_r.push |-> $past(emi_r);
    endproperty
    a_take_needs_emi: assert property (p_take_needs_emi) else $error("take while global enable low");
    property p_take_clears_emi;
        @(posedge ref_clk) disable iff (!rst_n) core_r.push |-> !emi_r ##1 !core_r.push;
    endproperty
    a_take_clears_emi: assert property (p_take_clears_emi) else $error("global enable kept after take");
    property p_no_take_stack_full;
        @(posedge ref_clk) disable iff (!rst_n) core_r.push |-> !$past(stack_full);
    endproperty
    a_no_take_stack_full: assert property (p_no_take_stack_full) else $error("take with stack full");
    property p_take_vectors;
        @(posedge ref_clk) disable iff (!rst_n)
            core_r.push |-> core_r.pc_load && core_r.push_value == $past(next_pc);
    endproperty
    a_take_vectors: assert property (p_take_vectors) else $error("take did not push next address");
    property p_return_from_interrupt_pops;
        @(posedge ref_clk) disable iff (!rst_n)
            return_from_interrupt |=> core_r.pop && core_r.pc_load && core_r.pc_value == $past(stack_top);
    endproperty
    a_return_from_interrupt_pops: assert property (p_return_from_interrupt_pops) else $error("return did not restore counter");
    property p_take_needs_enable;
        @(posedge ref_clk) disable iff (!rst_n)
            core_r.push |-> (($past(src_en_r & src_flag_r) >> core_r.src) & 6'h01) != 6'h00;
    endproperty
    a_take_needs_enable: assert property (p_take_needs_enable) else $error("take of disabled source");
    property p_event_sets_flag;
        @(posedge ref_clk) disable iff (!rst_n) (sub_evt != '0) |=> ((sub_flag_r & $past(sub_evt)) == $past(sub_evt));
    endproperty
    a_event_sets_flag: assert property (p_event_sets_flag) else $error("event lost its flag");
    property p_wake;
        @(posedge ref_clk) disable iff (!rst_n) ((|src_flag_r) || (|sub_flag_r)) |=> wake_r;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake with flag set");
    property p_ext_cleared;
        @(posedge ref_clk) disable iff (!rst_n)
            core_r.push && core_r.src == `MIC_SRC_INT0 && !$past(ext_evt[0]) |-> !src_flag_r[`MIC_SRC_INT0];
    endproperty
    a_ext_cleared: assert property (p_ext_cleared) else $error("pin flag not cleared on service");
    property p_timer0_match_irq_ctrl_reserved;
        @(posedge ref_clk) disable iff (!rst_n)
            $past(reg_rd) && $past(reg_addr) == `MIC_OFF_TIMER0_MATCH_IRQ_CTRL |-> (reg_rdata_r & `MIC_TIMER0_MATCH_IRQ_CTRL_RSVD) == 8'h00;
    endproperty
    a_timer0_match_irq_ctrl_reserved: assert property (p_timer0_match_irq_ctrl_reserved) else $error("reserved bits read nonzero");
    c_take: cover property (@(posedge ref_clk) disable iff (!rst_n) core_r.push);
    c_take_group: cover property (@(posedge ref_clk) disable iff (!rst_n) core_r.push && core_r.src == `MIC_SRC_MF1);
    c_return_from_interrupt: cover property (@(posedge ref_clk) disable iff (!rst_n) core_r.push ##[1:20] core_r.pop);
endmodule

//--- sim/mic_core_model.sv
/* Core model for mic_top: a running program counter and a shallow stack.
 Assumes push and pop commands are one-cycle pulses on ref_clk. */
`timescale 1ns/100ps
`include "mic_cfg.svh"
module mic_core_model import mic_pkg::*; #(parameter int DEPTH = 1) (
    // Clock, reset, commands
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire mic_core_out_t core,
    // Counter and stack
    output logic [`MIC_PC_W-1:0] next_pc,
    output logic [`MIC_PC_W-1:0] stack_top,
    output logic stack_full
);
    logic [`MIC_PC_W-1:0] stk [DEPTH];
    int sp;
    // Empty stack shows a pattern, so a stale value never passes
    assign stack_top = (sp > 0) ? stk[sp-1] : 13'h1555;
    assign stack_full = (sp == DEPTH);
    // Counter runs on; a push keeps the address it was handed
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sp <= 0;
            next_pc <= 13'h0100;
        end else begin
            next_pc <= next_pc + 13'h0001;
            if (core.push && sp < DEPTH) stk[sp] <= core.push_value;
            sp <= sp + int'(core.push) - int'(core.pop);
        end
    end
endmodule

//--- sim/mic_top_test.sv
/* Testbench of mic_top: registers, gating, vectoring, stack hold-off, pin edge.
 Assumes a one-deep core stack, so one taken interrupt fills it. */
`timescale 1ns/100ps
`include "mic_cfg.svh"
module mic_top_test import mic_pkg::*; ;
    logic ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rfi = 0, ee = 0, lv = 0, cmp = 0;
    logic [3:0] addr = 0;
    logic [7:0] wd = 0, g;
    logic [1:0] pin = 0, dir = 0;
    logic [12:0] sv;
    mic_tm_evt_t tm = '0;
    wire [7:0] rdata;
    mic_core_out_t core;
    wire wake, sfull;
    wire [12:0] npc, stop;
    int num_errors = 0, checked = 0;
    always #5 ref_clk = ~ref_clk;
    mic_top i_mic_top (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wd), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_r(rdata), .tm_evt(tm), .eeprom_done_evt(ee), .low_voltage_evt(lv),
        .ext_pin_in(pin), .ext_pin_dir_in(dir), .comparator_out(cmp), .next_pc(npc), .stack_top(stop),
        .stack_full(sfull), .return_from_interrupt(rfi), .core_r(core), .wake_r(wake));
    mic_core_model i_mic_core_model (.ref_clk(ref_clk), .rst_n(rst_n), .core(core), .next_pc(npc),
        .stack_top(stop), .stack_full(sfull));
    task chk(input logic [12:0] got, input logic [12:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk) {reg_wr, addr, wd} <= {1'b1, a, d};
        @(posedge ref_clk) reg_wr <= 0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge ref_clk) {reg_rd, addr} <= {1'b1, a};
        @(posedge ref_clk) reg_rd <= 0;
        #1 g = rdata;
    endtask
    // Timer 0 compare-A pulse, one cycle long
    task evt;
        @(posedge ref_clk) tm.cmpa <= 3'h1;
        @(posedge ref_clk) tm.cmpa <= 3'h0;
    endtask
    // Watch a bounded span for an acknowledge and judge its vector
    task take(input logic exp, input logic [12:0] vec);
        logic got;
        got = 0;
        repeat (12) begin
            @(posedge ref_clk) #1;
            if (core.ack === 1'b1 && !got) begin
                got = 1;
                sv = npc - 13'h0001;
                chk(core.pc_value, vec);
                chk(core.push_value, sv);
                chk({core.push, core.pc_load}, 2'b11);
            end
        end
        chk(got, exp);
    endtask
    task ret;
        @(posedge ref_clk) rfi <= 1;
        @(posedge ref_clk) rfi <= 0;
        #1 chk(core.pop, 1'b1);
        chk(core.pc_value, sv);
    endtask
    task summarize;
        if (num_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #20000;
        num_errors++;
        summarize;
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1;
        for (int a = 0; a < 9; a++) begin
            rd(a[3:0]);
            chk(g, 0);
        end
        wr(4, 8'hFF); rd(4); chk(g, 8'h33);
        chk(wake, 1);
        wr(5, 8'hFF); rd(5); chk(g, 8'hFF);
        wr(6, 8'hFF); rd(6); chk(g, 8'h33);
        wr(4, 0); wr(5, 0); wr(6, 0); wr(2, 0);
        @(posedge ref_clk) {ee, lv} <= 2'b11;
        @(posedge ref_clk) {ee, lv} <= 2'b00;
        rd(6); chk(g, 8'h30);
        wr(1, 8'h09); evt; take(0, 0);
        rd(4); chk(g, 8'h20);
        chk(wake, 1);
        wr(4, 8'h02); wr(1, 8'h08); evt; take(0, 0);
        rd(1); chk(g, 8'h48);
        wr(1, 8'h49); take(1, 13'h000C);
        rd(1); chk(g, 8'h08);
        rd(4); chk(g, 8'h22);
        wr(4, 8'h02); wr(1, 8'h09); evt; take(0, 0);
        ret; take(1, 13'h000C);
        ret; wr(4, 0); wr(0, 8'h01); wr(1, 8'h03);
        @(posedge ref_clk) pin <= 2'b01;
        take(0, 0);
        @(posedge ref_clk) {dir, pin} <= 4'b0100;
        take(0, 0);
        @(posedge ref_clk) pin <= 2'b01;
        take(1, 13'h0004);
        rd(1); chk(g, 8'h02);
        ret;
        // Comparator: falling edge selected, so the rise must not trigger
        wr(7, 8'h02); wr(1, 8'h05);
        @(posedge ref_clk) cmp <= 1;
        take(0, 0);
        @(posedge ref_clk) cmp <= 0;
        take(1, 13'h0008);
        rd(1); chk(g, 8'h04);
        ret;
        // Both pending: pin 0 outranks the comparator
        wr(1, 8'h37); take(1, 13'h0004);
        ret;
        wr(1, 8'h25); take(1, 13'h0008);
        ret;
        summarize;
    end
endmodule
